// ---- hw/sbas_arb_if.sv ----
// Request and grant carrier between the top and the rotating arbiter
`default_nettype none
interface sbas_arb_if;
  import sbas_pkg::*;
  logic [SBAS_NREQ-1:0] req;
  logic [SBAS_NREQ-1:0] gnt;
  logic internalEn;
  logic busIdle;
  modport arb (input req, input internalEn, input busIdle, output gnt);
  modport ctl (output req, output internalEn, output busIdle, input gnt);
endinterface
`default_nettype wire

// ---- hw/sbas_arbiter.sv ----
// Rotating-priority arbiter over the secondary requests
`default_nettype none
module sbas_arbiter
  import sbas_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  sbas_arb_if.arb arb
);
  logic [SBAS_NREQ-1:0] lastGnt;
  logic [SBAS_NREQ-1:0] next_gnt;
  logic [SBAS_NREQ-1:0] picked;
  logic holderReq;
  logic rearb;

  // First requester after the last winner, wrapping round
  function automatic logic [SBAS_NREQ-1:0] sbas_pick(
    input logic [SBAS_NREQ-1:0] req,
    input logic [SBAS_NREQ-1:0] last
  );
    logic [SBAS_NREQ-1:0] res;
    logic found;
    int start;
    int j;
    res = '0;
    found = 1'b0;
    start = 0;
    j = 0;
    for (int k = 0; k < SBAS_NREQ; k++)
    begin
      if (last[k])
      begin
        start = k;
      end
    end
    for (int i = 1; i <= SBAS_NREQ; i++)
    begin
      j = (start + i) % SBAS_NREQ;
      if (!found && req[j])
      begin
        res[j] = 1'b1;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  assign picked = sbas_pick(arb.req, lastGnt);
  assign holderReq = |(arb.gnt & arb.req);
  // Move on when the holder drops or has taken the bus
  assign rearb = !holderReq || !arb.busIdle;
  assign next_gnt = !arb.internalEn ? '0 : (rearb ? picked : arb.gnt);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      arb.gnt <= '0;
      lastGnt <= '0;
    end
    else
    begin
      arb.gnt <= next_gnt;
      lastGnt <= (next_gnt != '0) ? next_gnt : lastGnt;
    end
  end

  a_gnt_onehot: assert property (@(posedge clk) disable iff (!rst_b) $onehot0(arb.gnt))
    else $error("More than one grant active");
  a_gnt_has_req: assert property (@(posedge clk) disable iff (!rst_b)
    (arb.gnt != '0 && $changed(arb.gnt)) |-> ((arb.gnt & $past(arb.req)) != '0))
    else $error("Grant given without a request");
  // No grants when the arbiter is off
  a_ext_no_grant: assert property (@(posedge clk) disable iff (!rst_b)
    !arb.internalEn |=> arb.gnt == '0)
    else $error("Grant while internal arbiter disabled");
endmodule
`default_nettype wire

// ---- hw/sbas_parity.sv ----
// Secondary data parity check and parity error line driver
`default_nettype none
module sbas_parity
  import sbas_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic busIdle,
  input wire logic rxValid,
  input wire logic rxReceiver,
  input wire logic [31:0] rxData,
  input wire logic [3:0] rxCbe,
  input wire logic sec_parity_bit,
  output logic sec_parity_err_n,
  output logic sec_parity_err_oe
);
  logic rxTaken;
  logic dataPar;
  logic tail;
  logic parErr;
  logic driveNow;
  logic next_oe;
  logic next_tail;

  // Even parity over data, byte enables and parity bit
  assign parErr = rxTaken && (dataPar ^ sec_parity_bit);
  // Drive only while this side receives the data
  assign driveNow = parErr || (rxReceiver && !busIdle);
  // One deasserted clock on idle, then release
  assign next_oe = driveNow || (sec_parity_err_oe && !(busIdle && tail));
  assign next_tail = !driveNow && sec_parity_err_oe && busIdle && !tail;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxTaken <= 1'b0;
      dataPar <= 1'b0;
      tail <= 1'b0;
      sec_parity_err_n <= 1'b1;
      sec_parity_err_oe <= 1'b0;
    end
    else
    begin
      // Word at n, parity at n+1, error at n+2
      rxTaken <= rxValid && rxReceiver;
      dataPar <= ^{rxData, rxCbe};
      tail <= next_tail;
      sec_parity_err_n <= !parErr;
      sec_parity_err_oe <= next_oe;
    end
  end

  // Error shows two clocks after the word
  a_perr_timing: assert property (@(posedge clk) disable iff (!rst_b)
    (rxValid && rxReceiver) ##1 (^{$past(rxData), $past(rxCbe), sec_parity_bit})
    |=> (!sec_parity_err_n && sec_parity_err_oe))
    else $error("Parity error not flagged on time");
  // Release after the idle deasserted clock
  a_perr_release: assert property (@(posedge clk) disable iff (!rst_b)
    (sec_parity_err_oe && busIdle && tail && !driveNow) |=> !sec_parity_err_oe)
    else $error("Parity error line not released after idle");
endmodule
`default_nettype wire

// ---- hw/sbas_pkg.sv ----
// Shared constants and types for the secondary bus arbiter and sideband logic
`default_nettype none
package sbas_pkg;
  // Number of secondary request and grant pairs
  localparam int SBAS_NREQ = 9;
  // Synchroniser depth for pin inputs
  localparam int SBAS_SYNC_STAGES = 2;
  // Reset values of active-low pins and strap settle pattern
  localparam logic [8:0] SBAS_GNT_RESET = 9'h1ff;
  localparam logic [8:0] SBAS_PIN_IDLE = 9'h1ff;
  localparam logic [1:0] SBAS_SETTLE_RESET = 2'h0;
  localparam logic [1:0] SBAS_SETTLE_LATCH = 2'h1;
  localparam logic [1:0] SBAS_SETTLE_DONE = 2'h3;
  // Lock line driver states
  typedef enum logic [3:0] {
    SBAS_LK_IDLE = 4'b0001,
    SBAS_LK_ADDR = 4'b0010,
    SBAS_LK_HELD = 4'b0100,
    SBAS_LK_REL = 4'b1000
  } sbas_lock_t;
endpackage
`default_nettype wire

// ---- hw/sbas_top.sv ----
// Secondary bus arbiter, lock, parity and system error sideband
// Contract
// - Locked transactions go downstream only, never toward the primary bus.
// - Keep lock asserted until next locked address phase or release.
// - On release drive lock high one clock, then stop driving.
// - Receiver asserts parity error when received data parity fails.
// - Parity error one clock after parity bit, two after data.
// - Target drives parity error on writes, initiator on reads.
// - On idle drive parity error high one clock, then release.
// - Never drive secondary system error; sample it, forward to primary.
// - Accept nine active-low requests and service them by priority.
// - Drive nine independent active-low grants by priority.
// - Strap low enables internal arbiter; strap high disables it.
// - External mode: request 0 is grant in, grant 0 is request out.
// - External mode: start only with grant asserted and bus idle.
// - External mode: park when entries empty, grant asserted, bus idle.
// - Downstream lock: deasserted in first address phase, asserted next clock.
`default_nettype none
module sbas_top
  import sbas_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [SBAS_NREQ-1:0] secReqN,
  output logic [SBAS_NREQ-1:0] secGntN,
  input wire logic central_function_en_n,
  input wire logic sec_system_err_n,
  output logic pri_system_err_n,
  output logic pri_system_err_oe,
  input wire logic serrForwardEn,
  input wire logic busIdle,
  input wire logic bridgeReq,
  input wire logic entriesEmpty,
  output logic busMayStart,
  output logic busPark,
  input wire logic lockStart,
  input wire logic lockDownstream,
  input wire logic lockRelease,
  output logic secLockN,
  output logic secLockOe,
  input wire logic rxValid,
  input wire logic rxReceiver,
  input wire logic [31:0] rxData,
  input wire logic [3:0] rxCbe,
  input wire logic sec_parity_bit,
  output logic sec_parity_err_n,
  output logic sec_parity_err_oe
);
  logic [SBAS_NREQ-1:0] reqS1;
  logic [SBAS_NREQ-1:0] reqS2;
  logic cfnS1;
  logic cfnS2;
  logic serrS1;
  logic serrS2;
  logic [1:0] settle;
  logic modeReady;
  logic internalEn;
  logic [SBAS_NREQ-1:0] reqActive;
  logic extGnt;
  logic anyReq;
  logic next_mayStart;
  logic next_park;
  logic [SBAS_NREQ-1:0] next_gntN;
  logic serrSeen;
  logic startOk;
  sbas_lock_t lockState;
  sbas_lock_t next_lockState;

  sbas_arb_if arbBus();

  // Pin synchronisers and strap capture
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reqS1 <= SBAS_PIN_IDLE;
      reqS2 <= SBAS_PIN_IDLE;
      cfnS1 <= 1'b1;
      cfnS2 <= 1'b1;
      serrS1 <= 1'b1;
      serrS2 <= 1'b1;
      settle <= SBAS_SETTLE_RESET;
    end
    else
    begin
      reqS1 <= secReqN;
      reqS2 <= reqS1;
      cfnS1 <= central_function_en_n;
      cfnS2 <= cfnS1;
      serrS1 <= sec_system_err_n;
      serrS2 <= serrS1;
      settle <= {settle[0], 1'b1};
    end
  end

  // Strap sampled once after reset release
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      modeReady <= 1'b0;
      internalEn <= 1'b0;
    end
    else if (settle == SBAS_SETTLE_DONE && !modeReady)
    begin
      modeReady <= 1'b1;
      internalEn <= !cfnS2;
    end
  end

  assign reqActive = ~reqS2;
  // Request 0 is the external grant in that mode
  assign extGnt = reqActive[0];
  assign anyReq = |reqActive;

  assign arbBus.req = reqActive;
  assign arbBus.internalEn = internalEn && modeReady;
  assign arbBus.busIdle = busIdle;

  sbas_arbiter u_arbiter (
    .clk(clk),
    .rst_b(rst_b),
    .arb(arbBus)
  );

  // Grants out; in external mode grant 0 carries bridge request
  assign next_gntN = !modeReady ? SBAS_GNT_RESET :
                     internalEn ? ~arbBus.gnt :
                     {SBAS_GNT_RESET[SBAS_NREQ-1:1], !bridgeReq};
  // Start only with the bus idle and ownership
  assign next_mayStart = modeReady && busIdle &&
                         (internalEn ? (arbBus.gnt == '0 && !anyReq) : extGnt);
  // Park an idle bus when nothing is queued
  assign next_park = modeReady && busIdle && entriesEmpty &&
                     (internalEn ? !anyReq : extGnt);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      secGntN <= SBAS_GNT_RESET;
      busMayStart <= 1'b0;
      busPark <= 1'b0;
    end
    else
    begin
      secGntN <= next_gntN;
      busMayStart <= next_mayStart;
      busPark <= next_park;
    end
  end

  // Input only; forwarded as open drain when enabled
  assign serrSeen = !serrS2 && serrForwardEn;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pri_system_err_n <= 1'b1;
      pri_system_err_oe <= 1'b0;
    end
    else
    begin
      pri_system_err_n <= !serrSeen;
      pri_system_err_oe <= serrSeen;
    end
  end

  // Only downstream locked starts drive the lock line
  assign startOk = lockStart && lockDownstream;

  // Lock line state machine
  always_comb
  begin
    next_lockState = lockState;
    unique case (lockState)
      SBAS_LK_IDLE:
      begin
        if (startOk)
        begin
          next_lockState = SBAS_LK_ADDR;
        end
      end
      SBAS_LK_ADDR:
      begin
        // Assert one clock after the address phase
        next_lockState = lockRelease ? SBAS_LK_REL : SBAS_LK_HELD;
      end
      SBAS_LK_HELD:
      begin
        if (lockRelease)
        begin
          next_lockState = SBAS_LK_REL;
        end
      end
      SBAS_LK_REL:
      begin
        next_lockState = SBAS_LK_IDLE;
      end
      default:
      begin
        next_lockState = SBAS_LK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lockState <= SBAS_LK_IDLE;
      secLockN <= 1'b1;
      secLockOe <= 1'b0;
    end
    else
    begin
      lockState <= next_lockState;
      secLockN <= next_lockState != SBAS_LK_HELD;
      secLockOe <= next_lockState != SBAS_LK_IDLE;
    end
  end

  sbas_parity u_parity (
    .clk(clk),
    .rst_b(rst_b),
    .busIdle(busIdle),
    .rxValid(rxValid),
    .rxReceiver(rxReceiver),
    .rxData(rxData),
    .rxCbe(rxCbe),
    .sec_parity_bit(sec_parity_bit),
    .sec_parity_err_n(sec_parity_err_n),
    .sec_parity_err_oe(sec_parity_err_oe)
  );

  // Address phase high, asserted next clock
  a_lock_addr: assert property (@(posedge clk) disable iff (!rst_b)
    (lockState == SBAS_LK_IDLE && startOk) ##1 !lockRelease |->
    (secLockOe && secLockN) ##1 (secLockOe && !secLockN))
    else $error("Lock not driven high then low at start");
  a_lock_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (lockState == SBAS_LK_HELD && !lockRelease) |=> (secLockOe && !secLockN))
    else $error("Lock dropped without release");
  a_lock_release: assert property (@(posedge clk) disable iff (!rst_b)
    (lockState == SBAS_LK_HELD && lockRelease) |=>
    (secLockOe && secLockN) ##1 !secLockOe)
    else $error("Lock release sequence wrong");
  // Upstream lock never drives the line
  a_lock_upstream: assert property (@(posedge clk) disable iff (!rst_b)
    (lockState == SBAS_LK_IDLE && lockStart && !lockDownstream) |=> !secLockOe)
    else $error("Upstream lock propagated");
  a_serr_forward: assert property (@(posedge clk) disable iff (!rst_b)
    (!sec_system_err_n && serrForwardEn) ##1 serrForwardEn ##1 serrForwardEn
    |=> (!pri_system_err_n && pri_system_err_oe))
    else $error("System error not forwarded");
  // Park only on an idle bus
  a_park_idle: assert property (@(posedge clk) disable iff (!rst_b)
    busPark |-> ($past(busIdle) && $past(entriesEmpty)))
    else $error("Park without idle bus and empty entries");
  a_ext_start: assert property (@(posedge clk) disable iff (!rst_b)
    (busMayStart && !internalEn) |-> ($past(extGnt) && $past(busIdle)))
    else $error("External mode start without grant");
  a_strap_held: assert property (@(posedge clk) disable iff (!rst_b)
    modeReady |=> (modeReady && $stable(internalEn)))
    else $error("Arbiter mode changed after latch");
  a_no_early_grant: assert property (@(posedge clk) disable iff (!rst_b)
    !modeReady |=> (secGntN == SBAS_GNT_RESET && !busMayStart && !busPark))
    else $error("Grant or start before arbiter mode latched");
  a_gnt_pins: assert property (@(posedge clk) disable iff (!rst_b)
    (modeReady && internalEn) |=> (secGntN == ~$past(arbBus.gnt)))
    else $error("Grant pins differ from arbiter choice");
  a_ext_gnt_out: assert property (@(posedge clk) disable iff (!rst_b)
    (modeReady && !internalEn) |=>
    (secGntN == {SBAS_GNT_RESET[SBAS_NREQ-1:1], !$past(bridgeReq)}))
    else $error("External mode grant pins wrong");
  a_serr_blocked: assert property (@(posedge clk) disable iff (!rst_b)
    !serrForwardEn |=> !pri_system_err_oe)
    else $error("System error forwarded while disabled");
  a_serr_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    sec_system_err_n |-> ##3 pri_system_err_n)
    else $error("Primary system error without secondary error");
  a_start_busy: assert property (@(posedge clk) disable iff (!rst_b)
    !busIdle |=> (!busMayStart && !busPark))
    else $error("Start or park on a busy bus");
  a_park_ext: assert property (@(posedge clk) disable iff (!rst_b)
    (modeReady && !internalEn && busIdle && entriesEmpty && extGnt) |=> busPark)
    else $error("Bus not parked with grant on idle bus");
endmodule
`default_nettype wire

// ---- sim/sbas_sec_devices.sv ----
// Secondary bus devices and external arbiter facing the bridge
`default_nettype none
module sbas_sec_devices
  import sbas_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [SBAS_NREQ-1:0] want,
  input wire logic extArb,
  input wire logic extGive,
  input wire logic serrAssert,
  input wire logic busIdle,
  input wire logic [SBAS_NREQ-1:0] secGntN,
  output logic [SBAS_NREQ-1:0] secReqN,
  output logic sec_system_err_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [SBAS_NREQ-1:0] owned;
  logic [SBAS_NREQ-1:0] served;
  logic [SBAS_NREQ-1:0] devReqN;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      owned <= '0;
      served <= '0;
    end
    else
    begin
      owned <= ~secGntN & {SBAS_NREQ{busIdle}} & want;
      served <= (served | (owned & ~secGntN)) & want;
    end
  end
  assign devReqN = ~(want & ~served);
  // External arbiter answers the bridge request
  assign secReqN = extArb ? {devReqN[SBAS_NREQ-1:1], secGntN[0] | ~extGive} : devReqN;
  assign sec_system_err_n = serrAssert ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ---- sim/sbas_top_tb.sv ----
// Self-checking bench for the secondary arbiter and sideband block
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module sbas_top_tb
  import sbas_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_b, central_function_en_n, serrForwardEn, busIdle, bridgeReq, entriesEmpty;
  logic lockStart, lockDownstream, lockRelease, rxValid, rxReceiver, sec_parity_bit;
  logic extArb, extGive, serrAssert, sec_system_err_n, pri_system_err_n, pri_system_err_oe;
  logic busMayStart, busPark, secLockN, secLockOe, sec_parity_err_n, sec_parity_err_oe;
  logic [31:0] rxData;
  logic [3:0] rxCbe;
  logic [8:0] want, secReqN, secGntN;
  int mismatches = 0;
  int comparisons = 0;
  sbas_top sbas_top_inst (.clk, .rst_b, .secReqN, .secGntN, .central_function_en_n,
    .sec_system_err_n, .pri_system_err_n, .pri_system_err_oe, .serrForwardEn, .busIdle,
    .bridgeReq, .entriesEmpty, .busMayStart, .busPark, .lockStart, .lockDownstream,
    .lockRelease, .secLockN, .secLockOe, .rxValid, .rxReceiver, .rxData, .rxCbe,
    .sec_parity_bit, .sec_parity_err_n, .sec_parity_err_oe);
  sbas_sec_devices sbas_sec_devices_inst (.clk, .rst_b, .want, .extArb, .extGive,
    .serrAssert, .busIdle, .secGntN, .secReqN, .sec_system_err_n);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic do_reset(input logic strap);
    @(posedge clk);
    rst_b <= 1'b0;
    central_function_en_n <= strap;
    extArb <= strap;
    repeat (2) @(posedge clk);
    #1 `CHK(secGntN, SBAS_GNT_RESET)
    `CHK({secLockOe, sec_parity_err_oe, pri_system_err_oe, busMayStart, busPark}, 5'h00)
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic sc_grant_latency();
    @(posedge clk) #1 `CHK(busMayStart, 1'b1)
    @(posedge clk);
    want <= 9'h008;
    repeat (3) @(posedge clk);
    #1 `CHK(secGntN, SBAS_GNT_RESET)
    @(posedge clk) #1 `CHK(secGntN, 9'h1f7)
    `CHK(busMayStart, 1'b0)
    @(posedge clk);
    want <= '0;
    repeat (8) @(posedge clk);
  endtask
  task automatic sc_round_robin();
    logic [8:0] prev;
    int seen;
    int idx;
    prev = SBAS_GNT_RESET;
    seen = 0;
    // Rotation resumes after device 3, the last one granted
    idx = 4;
    @(posedge clk);
    want <= 9'h1ff;
    for (int n = 0; n < 400 && seen < 9; n++)
    begin
      @(posedge clk) #1;
      if (secGntN !== prev && secGntN !== SBAS_GNT_RESET)
      begin
        `CHK(secGntN, ~(9'h001 << idx))
        idx = (idx + 1) % SBAS_NREQ;
        seen++;
        prev = secGntN;
      end
    end
    `CHK(seen, 9)
    if (seen != 9)
      results();
    want <= '0;
    repeat (8) @(posedge clk);
  endtask
  task automatic sc_lock();
    @(posedge clk);
    lockStart <= 1'b1;
    @(posedge clk);
    lockStart <= 1'b0;
    repeat (2) @(posedge clk) #1 `CHK(secLockOe, 1'b0)
    @(posedge clk);
    lockStart <= 1'b1;
    lockDownstream <= 1'b1;
    @(posedge clk);
    lockStart <= 1'b0;
    #1 `CHK({secLockOe, secLockN}, 2'b11)
    @(posedge clk);
    lockStart <= 1'b1;
    for (int n = 0; n < 4; n++)
    begin
      @(posedge clk);
      lockStart <= 1'b0;
      #1 `CHK({secLockOe, secLockN}, 2'b10)
    end
    @(posedge clk);
    lockRelease <= 1'b1;
    @(posedge clk);
    lockRelease <= 1'b0;
    lockDownstream <= 1'b0;
    #1 `CHK({secLockOe, secLockN}, 2'b11)
    @(posedge clk) #1 `CHK(secLockOe, 1'b0)
  endtask
  task automatic word(input logic [31:0] d, input logic [3:0] c, input logic bad);
    @(posedge clk);
    rxValid <= 1'b1;
    rxData <= d;
    rxCbe <= c;
    @(posedge clk);
    rxValid <= 1'b0;
    sec_parity_bit <= ^{d, c} ^ bad;
  endtask
  task automatic sc_parity();
    @(posedge clk);
    busIdle <= 1'b0;
    rxReceiver <= 1'b1;
    word(32'h8000_0001, 4'ha, 1'b1);
    #1 `CHK({sec_parity_err_oe, sec_parity_err_n}, 2'b11)
    @(posedge clk) #1 `CHK({sec_parity_err_oe, sec_parity_err_n}, 2'b10)
    @(posedge clk) #1 `CHK({sec_parity_err_oe, sec_parity_err_n}, 2'b11)
    word(32'h1234_5678, 4'h3, 1'b0);
    @(posedge clk) #1 `CHK({sec_parity_err_oe, sec_parity_err_n}, 2'b11)
    @(posedge clk);
    busIdle <= 1'b1;
    @(posedge clk) #1 `CHK({sec_parity_err_oe, sec_parity_err_n}, 2'b11)
    @(posedge clk) #1 `CHK(sec_parity_err_oe, 1'b0)
    @(posedge clk);
    busIdle <= 1'b0;
    rxReceiver <= 1'b0;
    word(32'h0000_00ff, 4'hf, 1'b1);
    @(posedge clk) #1 `CHK(sec_parity_err_oe & ~sec_parity_err_n, 1'b0)
    @(posedge clk);
    busIdle <= 1'b1;
  endtask
  task automatic sc_serr();
    @(posedge clk);
    serrAssert <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK(pri_system_err_oe, 1'b0)
    @(posedge clk) #1 `CHK({pri_system_err_oe, pri_system_err_n}, 2'b10)
    @(posedge clk);
    serrForwardEn <= 1'b0;
    repeat (2) @(posedge clk) #1 `CHK(pri_system_err_oe, 1'b0)
    @(posedge clk);
    serrAssert <= 1'b0;
    serrForwardEn <= 1'b1;
  endtask
  task automatic sc_external();
    do_reset(1'b1);
    extGive <= 1'b1;
    bridgeReq <= 1'b1;
    entriesEmpty <= 1'b0;
    want <= 9'h1fe;
    @(posedge clk) #1 `CHK(secGntN, 9'h1fe)
    for (int n = 0; n < 8 && busMayStart !== 1'b1; n++)
      @(posedge clk) #1;
    `CHK({busMayStart, busPark}, 2'b10)
    `CHK(secGntN[8:1], 8'hff)
    if (busMayStart !== 1'b1)
      results();
    @(posedge clk);
    entriesEmpty <= 1'b1;
    @(posedge clk) #1 `CHK(busPark, 1'b1)
    @(posedge clk);
    busIdle <= 1'b0;
    @(posedge clk) #1 `CHK({busMayStart, busPark}, 2'b00)
    @(posedge clk);
    busIdle <= 1'b1;
    extGive <= 1'b0;
    repeat (4) @(posedge clk);
    #1 `CHK({busMayStart, busPark}, 2'b00)
  endtask
  initial
  begin
    rst_b = 1'b0;
    central_function_en_n = 1'b0;
    serrForwardEn = 1'b1;
    busIdle = 1'b1;
    bridgeReq = 1'b0;
    entriesEmpty = 1'b1;
    lockStart = 1'b0;
    lockDownstream = 1'b0;
    lockRelease = 1'b0;
    rxValid = 1'b0;
    rxReceiver = 1'b0;
    rxData = '0;
    rxCbe = '0;
    sec_parity_bit = 1'b0;
    extArb = 1'b0;
    extGive = 1'b0;
    serrAssert = 1'b0;
    want = '0;
    do_reset(1'b0);
    sc_grant_latency();
    sc_round_robin();
    sc_lock();
    sc_parity();
    sc_serr();
    sc_external();
    results();
  end
endmodule
`default_nettype wire
